// *** hw/ccs_pkg.sv ***
// Constants and types for the core clock and sleep controller.
// Assumes a single 50 MHz system clock drives all controller logic.
package ccs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SEC_NS        = 1_000_000_000;
    localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
    localparam int unsigned WAKE_MAX_NS   = 1_000_000;
    localparam int unsigned WAKE_MAX_CYC  = WAKE_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned HALF_MHZ_HZ   = 500_000;
    localparam int unsigned HZ_PER_MS     = 1_000;
    localparam int unsigned HALF_MHZ_PER_MS = HALF_MHZ_HZ / HZ_PER_MS;

    // ------------------------------------------------------------
    // Frequency codes, in units of 0.5 MHz
    // ------------------------------------------------------------
    localparam int unsigned FW     = 8;
    localparam int unsigned DIV_W  = 28;
    localparam int unsigned BAUD_W = 18;
    localparam int unsigned SMALL_N = 8;
    localparam int unsigned LARGE_N = 10;
    localparam logic [FW-1:0] SMALL_LIST [SMALL_N] = '{
        8'h60, 8'h50, 8'h3c, 8'h28, 8'h14, 8'h0a, 8'h02, 8'h01};
    localparam logic [FW-1:0] LARGE_LIST [LARGE_N] = '{
        8'hf0, 8'hc8, 8'ha0, 8'h78, 8'h60, 8'h50, 8'h3c, 8'h28,
        8'h14, 8'h0a};
    localparam logic [FW-1:0] F_SMALL_RESET = 8'h50;
    localparam logic [FW-1:0] F_LARGE_RESET = 8'hc8;
    localparam logic [FW-1:0] F_1MHZ        = 8'h02;
    localparam logic [FW-1:0] F_HALF_MHZ    = 8'h01;

    // ------------------------------------------------------------
    // Console limits and feature enables
    // ------------------------------------------------------------
    localparam logic [BAUD_W-1:0] BAUD_MAX_1MHZ = 18'h012c0;
    localparam logic [BAUD_W-1:0] BAUD_MAX_HALF = 18'h00960;
    localparam int unsigned FEAT_TICK  = 0;
    localparam int unsigned FEAT_I2C   = 1;
    localparam int unsigned FEAT_PULSE = 2;
    localparam int unsigned FEAT_TEMP  = 3;
    localparam int unsigned FEAT_IR    = 4;
    localparam int unsigned FEAT_COUNT = 5;
    localparam int unsigned FEAT_SECOND_SERIAL_PORT  = 6;
    localparam int unsigned FEAT_N     = 7;
    localparam logic [FEAT_N-1:0] FEAT_ALL = 7'h7f;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_UNTIMED = 2'b10,
        ST_TIMED   = 2'b01,
        ST_WAKE    = 2'b11
    } ccs_state_t;

    typedef enum logic [1:0] {
        DV_IDLE = 2'b00,
        DV_CON  = 2'b01,
        DV_UART = 2'b11
    } ccs_div_t;

endpackage

// *** hw/ccs_divider.sv ***
// Sequential restoring divider, one quotient bit per clock.
// Assumes the caller holds no second start while busy.
module ccs_divider
    import ccs_pkg::*;
#(
    parameter int unsigned W = DIV_W
)(
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic         i_start,
    input  wire logic [W-1:0] i_num,
    input  wire logic [W-1:0] i_den,
    output logic              o_busy,
    output logic              o_done,
    output logic [W-1:0]      o_quot
);

    logic [W-1:0]         num_q;
    logic [W-1:0]         den_q;
    logic [W:0]           rem_q;
    logic [$clog2(W+1)-1:0] cnt_q;
    logic [W:0]           trial;

    always_comb
    begin
        trial = {rem_q[W-1:0], num_q[W-1]};
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            num_q  <= '0;
            den_q  <= '0;
            rem_q  <= '0;
            cnt_q  <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_quot <= '0;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_start && !o_busy)
            begin
                num_q  <= i_num;
                den_q  <= i_den;
                rem_q  <= '0;
                cnt_q  <= ($clog2(W+1))'(W);
                o_busy <= 1'b1;
            end
            else if (o_busy)
            begin
                num_q <= {num_q[W-2:0], 1'b0};
                if (trial >= {1'b0, den_q})
                begin
                    rem_q  <= trial - {1'b0, den_q};
                    o_quot <= {o_quot[W-2:0], 1'b1};
                end
                else
                begin
                    rem_q  <= trial;
                    o_quot <= {o_quot[W-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == 1)
                begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

endmodule

// *** hw/ccs_top.sv ***
// Core clock selection, dependent rate correction and sleep control.
// Assumes wake and abort pins are asynchronous; all else is on i_sys_clk.
module ccs_top
    import ccs_pkg::*;
#(
    parameter bit          LARGE_VARIANT = 1'b0,
    parameter int unsigned SEC_CYC       = SEC_CYCLES,
    parameter int unsigned WAKE_MAX      = WAKE_MAX_CYC,
    parameter int unsigned SECS_W        = 16
)(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic              i_freq_req,
    input  wire logic [FW-1:0]     i_freq_half_mhz,
    input  wire logic [BAUD_W-1:0] i_console_baud,
    input  wire logic              i_uart_open,
    input  wire logic [BAUD_W-1:0] i_uart_baud,
    input  wire logic              i_sleep_req,
    input  wire logic [SECS_W-1:0] i_sleep_secs,
    input  wire logic              i_abort_en,
    input  wire logic              i_abort_pin,
    input  wire logic              i_wake_pin,
    input  wire logic              i_ir_active,
    output logic [FW-1:0]          o_freq_half_mhz,
    output logic                   o_freq_ack,
    output logic                   o_freq_reject,
    output logic [17:0]            o_ms_prescale,
    output logic [DIV_W-1:0]       o_console_div,
    output logic [DIV_W-1:0]       o_uart_div,
    output logic                   o_div_busy,
    output logic                   o_console_limited,
    output logic [FEAT_N-1:0]      o_feature_en,
    output logic                   o_core_halt,
    output logic                   o_wake_pin_input,
    output logic                   o_ir_decode_start,
    output logic                   o_time_advance,
    output logic [SECS_W-1:0]      o_slept_secs,
    output logic                   o_sleep_aborted
);

    // ------------------------------------------------------------
    // Frequency list
    // ------------------------------------------------------------
    function automatic logic freq_ok(input logic [FW-1:0] f);
        logic ok;
        ok = 1'b0;
        if (LARGE_VARIANT)
        begin
            for (int i = 0; i < LARGE_N; i++)
                if (f == LARGE_LIST[i])
                    ok = 1'b1;
        end
        else
        begin
            for (int i = 0; i < SMALL_N; i++)
                if (f == SMALL_LIST[i])
                    ok = 1'b1;
        end
        return ok;
    endfunction

    localparam logic [FW-1:0] F_RESET =
        LARGE_VARIANT ? F_LARGE_RESET : F_SMALL_RESET;

    function automatic logic is_low(input logic [FW-1:0] f);
        return (f == F_1MHZ) || (f == F_HALF_MHZ);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic       wake_s;
    logic       abort_s;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end
        else
        begin
            pin_meta_q <= {i_abort_pin, i_wake_pin};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign wake_s  = pin_sync_q[0];
    assign abort_s = pin_sync_q[1];

    // ------------------------------------------------------------
    // Frequency selection
    // ------------------------------------------------------------
    ccs_state_t      state_q;
    ccs_div_t        dv_q;
    logic            freq_go;
    logic            div_start;
    logic            div_done;
    logic            div_busy;
    logic [DIV_W-1:0] div_quot;
    logic [DIV_W-1:0] freq_hz;
    logic [BAUD_W-1:0] con_baud;
    logic              con_cap;

    assign freq_go = i_freq_req && (state_q == ST_RUN) &&
                     freq_ok(i_freq_half_mhz) && (dv_q == DV_IDLE);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_freq_half_mhz <= F_RESET;
            o_ms_prescale   <= 18'(F_RESET * HALF_MHZ_PER_MS);
            o_feature_en    <= FEAT_ALL;
            o_freq_ack      <= 1'b0;
            o_freq_reject   <= 1'b0;
        end
        else
        begin
            o_freq_ack    <= freq_go;
            o_freq_reject <= i_freq_req && !freq_go;
            if (freq_go)
            begin
                // SPI and PWM follow the core clock untouched; every o_feature_en bit, I2C included, is cleared at 1 MHz and 0.5 MHz
                o_freq_half_mhz <= i_freq_half_mhz;
                o_ms_prescale   <= 18'(i_freq_half_mhz *
                                       HALF_MHZ_PER_MS);
                o_feature_en    <= is_low(i_freq_half_mhz) ?
                                   '0 : FEAT_ALL;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial divisor recompute
    // ------------------------------------------------------------
    always_comb
    begin
        con_cap  = 1'b0;
        con_baud = i_console_baud;
        if (o_freq_half_mhz == F_1MHZ && i_console_baud > BAUD_MAX_1MHZ)
        begin
            con_cap  = 1'b1;
            con_baud = BAUD_MAX_1MHZ;
        end
        else if (o_freq_half_mhz == F_HALF_MHZ &&
                 i_console_baud > BAUD_MAX_HALF)
        begin
            con_cap  = 1'b1;
            con_baud = BAUD_MAX_HALF;
        end
    end

    assign freq_hz   = DIV_W'(o_freq_half_mhz * HALF_MHZ_HZ);
    assign div_start = (dv_q != DV_IDLE) && !div_busy && !div_done;

    ccs_divider #(.W(DIV_W)) u_div (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_start   (div_start),
        .i_num     (freq_hz),
        .i_den     (dv_q == DV_CON ? DIV_W'(con_baud)
                                   : DIV_W'(i_uart_baud)),
        .o_busy    (div_busy),
        .o_done    (div_done),
        .o_quot    (div_quot)
    );

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            dv_q              <= DV_CON;
            o_console_div     <= '0;
            o_uart_div        <= '0;
            o_div_busy        <= 1'b1;
            o_console_limited <= 1'b0;
        end
        else
        begin
            o_console_limited <= con_cap;
            unique case (dv_q)
                DV_IDLE:
                    if (freq_go)
                    begin
                        dv_q       <= DV_CON;
                        o_div_busy <= 1'b1;
                    end
                DV_CON:
                    if (div_done)
                    begin
                        o_console_div <= div_quot;
                        dv_q          <= i_uart_open ? DV_UART : DV_IDLE;
                        o_div_busy    <= i_uart_open;
                    end
                DV_UART:
                    if (div_done)
                    begin
                        o_uart_div <= div_quot;
                        dv_q       <= DV_IDLE;
                        o_div_busy <= 1'b0;
                    end
                default:
                    dv_q <= DV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------
    logic [31:0]       sec_cnt_q;
    logic              sec_tick;
    logic              wake_ref_q;
    logic              abort_ref_q;
    logic [SECS_W-1:0] target_q;
    logic              pin_edge;
    logic              abort_hit;
    logic              timed_q;

    assign sec_tick  = (sec_cnt_q == SEC_CYC - 1);
    assign pin_edge  = wake_s != wake_ref_q;
    // Sampling once a second needs a held abort level
    assign abort_hit = i_abort_en && (abort_s != abort_ref_q);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || state_q != ST_TIMED || sec_tick)
            sec_cnt_q <= '0;
        else
            sec_cnt_q <= sec_cnt_q + 32'h1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            state_q           <= ST_RUN;
            o_core_halt       <= 1'b0;
            o_wake_pin_input  <= 1'b0;
            o_ir_decode_start <= 1'b0;
            o_time_advance    <= 1'b0;
            o_slept_secs      <= '0;
            o_sleep_aborted   <= 1'b0;
            wake_ref_q        <= 1'b0;
            abort_ref_q       <= 1'b0;
            target_q          <= '0;
            timed_q           <= 1'b0;
        end
        else
        begin
            o_ir_decode_start <= 1'b0;
            o_time_advance    <= 1'b0;
            unique case (state_q)
                ST_RUN:
                    if (i_sleep_req && dv_q == DV_IDLE)
                    begin
                        o_core_halt     <= 1'b1;
                        o_sleep_aborted <= 1'b0;
                        o_slept_secs    <= '0;
                        target_q        <= i_sleep_secs;
                        wake_ref_q      <= wake_s;
                        abort_ref_q     <= abort_s;
                        timed_q         <= i_sleep_secs != '0;
                        if (i_sleep_secs == '0)
                        begin
                            o_wake_pin_input <= 1'b1;
                            state_q          <= ST_UNTIMED;
                        end
                        else
                            state_q <= ST_TIMED;
                    end
                ST_UNTIMED:
                    if (pin_edge)
                    begin
                        o_ir_decode_start <= i_ir_active;
                        o_wake_pin_input  <= 1'b0;
                        state_q           <= ST_WAKE;
                    end
                ST_TIMED:
                    if (sec_tick)
                    begin
                        o_slept_secs <= o_slept_secs + 1'b1;
                        if (abort_hit)
                        begin
                            o_sleep_aborted <= 1'b1;
                            state_q         <= ST_WAKE;
                        end
                        else if (o_slept_secs + 1'b1 == target_q)
                            state_q <= ST_WAKE;
                    end
                ST_WAKE:
                begin
                    o_time_advance <= timed_q;
                    o_core_halt    <= 1'b0;
                    state_q        <= ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [31:0] wake_lat_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || !o_core_halt || timed_q)
            wake_lat_q <= '0;
        else if (pin_edge || wake_lat_q != 0)
            wake_lat_q <= wake_lat_q + 32'h1;
    end

    a_freq_listed: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) freq_ok(o_freq_half_mhz))
        else $error("Core frequency outside the supported list");

    a_reset_freq: assert property (@(posedge i_sys_clk)
        i_rst |=> o_freq_half_mhz == F_RESET)
        else $error("Wrong power-on frequency");

    a_reject_keep: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        i_freq_req && !freq_ok(i_freq_half_mhz)
        |=> o_freq_reject && $stable(o_freq_half_mhz))
        else $error("Unsupported frequency not rejected");

    a_ms_follow: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        o_ms_prescale == 18'(o_freq_half_mhz * HALF_MHZ_PER_MS))
        else $error("Timekeeping prescale out of step");

    a_console_cap: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (dv_q == DV_CON && div_done && o_freq_half_mhz == F_HALF_MHZ)
        |=> o_console_div >= DIV_W'(HALF_MHZ_HZ / BAUD_MAX_HALF))
        else $error("Console baud above low-speed limit");

    a_low_feat: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        o_feature_en == (is_low(o_freq_half_mhz) ? '0 : FEAT_ALL))
        else $error("Feature enables disagree with frequency");

    a_halt_sleep: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (state_q == ST_RUN && i_sleep_req && dv_q == DV_IDLE)
        |=> o_core_halt throughout (state_q != ST_RUN)[*1])
        else $error("Core not halted in sleep");

    a_wake_edge: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (state_q == ST_UNTIMED && pin_edge)
        |=> state_q == ST_WAKE && o_ir_decode_start == $past(i_ir_active)
            ##1 !o_core_halt)
        else $error("Wake pin edge did not wake the core");

    a_wake_bound: assert property (@(posedge i_sys_clk)
        disable iff (i_rst) wake_lat_q < WAKE_MAX)
        else $error("Wake from pin took too long");

    a_timed_end: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (state_q == ST_TIMED && sec_tick && !abort_hit &&
         o_slept_secs + 1'b1 == target_q)
        |=> state_q == ST_WAKE ##1 o_time_advance && !o_core_halt)
        else $error("Timed sleep did not end on time");

    a_abort_wake: assert property (@(posedge i_sys_clk)
        disable iff (i_rst)
        (state_q == ST_TIMED && sec_tick && abort_hit)
        |=> state_q == ST_WAKE && o_sleep_aborted)
        else $error("Abort pin did not end timed sleep");

endmodule

// *** tb/ccs_pins.sv ***
// Partner model: external wake and abort pin sources.
// Assumes toggle commands arrive as one-cycle pulses on i_sys_clk.
module ccs_pins
#(
    parameter int HOLD = 20
)(
    input  wire logic i_sys_clk,
    input  wire logic i_wake_tgl,
    input  wire logic i_abort_tgl,
    output logic      o_wake_pin,
    output logic      o_abort_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int age;
    initial
    begin
        o_wake_pin  = 1'b0;
        o_abort_pin = 1'b0;
        age         = HOLD;
    end
    always @(posedge i_sys_clk)
    begin
        if (i_wake_tgl)
            o_wake_pin <= ~o_wake_pin; // Either edge wakes
        // New abort level is held at least one second
        if (i_abort_tgl && age >= HOLD)
        begin
            o_abort_pin <= ~o_abort_pin;
            age         <= 0;
        end
        else if (age < HOLD)
            age <= age + 1;
    end
endmodule

// *** tb/tb_ccs_top.sv ***
// Testbench for the core clock and sleep controller, small variant.
// Assumes ccs_pkg and ccs_top are compiled first.
module tb_ccs_top
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 20;
    typedef struct packed {logic ack; logic [FW-1:0] f;} ccs_exp_t;
    logic clk = 0, rst = 1, freq_req = 0, uart_open = 1, sleep_req = 0;
    logic abort_en = 0, ir_act = 1, wake_tgl = 0, abort_tgl = 0;
    logic wake_pin, abort_pin, o_freq_ack, o_freq_reject, o_div_busy;
    logic o_console_limited, o_core_halt, o_wake_pin_input;
    logic o_ir_decode_start, o_time_advance, o_sleep_aborted;
    logic [FW-1:0]     code = 8'h00, o_freq_half_mhz;
    logic [BAUD_W-1:0] cbaud = 18'h02580, ubaud = 18'h003e8;
    logic [15:0]       secs = 16'h0000, o_slept_secs;
    logic [17:0]       o_ms_prescale;
    logic [DIV_W-1:0]  o_console_div, o_uart_div;
    logic [DIV_W-1:0]  ud = '0;
    logic [FW-1:0]     cur = F_SMALL_RESET;
    logic [FEAT_N-1:0] o_feature_en;
    int bad_count = 0, samples_checked = 0, irs = 0, tadv = 0;
    ccs_exp_t expq[$];
    ccs_exp_t me;

    always #10 clk = ~clk;

    ccs_top #(.LARGE_VARIANT(1'b0), .SEC_CYC(SC), .WAKE_MAX(50),
              .SECS_W(16)) DUT (
        .i_sys_clk(clk), .i_rst(rst), .i_freq_req(freq_req),
        .i_freq_half_mhz(code), .i_console_baud(cbaud),
        .i_uart_open(uart_open), .i_uart_baud(ubaud),
        .i_sleep_req(sleep_req), .i_sleep_secs(secs),
        .i_abort_en(abort_en), .i_abort_pin(abort_pin),
        .i_wake_pin(wake_pin), .i_ir_active(ir_act),
        .o_freq_half_mhz(o_freq_half_mhz), .o_freq_ack(o_freq_ack),
        .o_freq_reject(o_freq_reject), .o_ms_prescale(o_ms_prescale),
        .o_console_div(o_console_div), .o_uart_div(o_uart_div),
        .o_div_busy(o_div_busy), .o_console_limited(o_console_limited),
        .o_feature_en(o_feature_en), .o_core_halt(o_core_halt),
        .o_wake_pin_input(o_wake_pin_input),
        .o_ir_decode_start(o_ir_decode_start),
        .o_time_advance(o_time_advance), .o_slept_secs(o_slept_secs),
        .o_sleep_aborted(o_sleep_aborted));

    ccs_pins #(.HOLD(SC)) pins (.i_sys_clk(clk), .i_wake_tgl(wake_tgl),
        .i_abort_tgl(abort_tgl), .o_wake_pin(wake_pin),
        .o_abort_pin(abort_pin));

    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (o_div_busy !== 1'b0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk(n < 200, "divider stuck busy");
    endtask

    // ------------------------------------------------------------
    // Frequency change with expected divisors
    // ------------------------------------------------------------
    task automatic set_freq(input logic [FW-1:0] c);
        logic ok;
        longint hz, cb;
        ok = 1'b0;
        foreach (SMALL_LIST[i])
            if (SMALL_LIST[i] == c)
                ok = 1'b1;
        expq.push_back('{ok, ok ? c : cur});
        if (ok)
            cur = c;
        @(posedge clk);
        freq_req <= 1'b1;
        code     <= c;
        @(posedge clk);
        freq_req <= 1'b0;
        @(negedge clk);
        @(negedge clk);
        wait_idle;
        if (ok)
        begin
            cb = cbaud;
            if (c == F_1MHZ && cb > BAUD_MAX_1MHZ)
                cb = BAUD_MAX_1MHZ;
            if (c == F_HALF_MHZ && cb > BAUD_MAX_HALF)
                cb = BAUD_MAX_HALF;
            hz = longint'(c) * 32'h0007a120;
            chk(o_ms_prescale === 18'(c * 32'h000001f4), "prescale");
            chk(o_feature_en === ((c == F_1MHZ || c == F_HALF_MHZ) ?
                7'h00 : FEAT_ALL), "features");
            chk(o_console_div === DIV_W'(hz / cb), "console div");
            chk(o_console_limited === (cb != cbaud), "limit");
            chk(o_uart_div === (uart_open ? DIV_W'(hz / ubaud) : ud),
                "uart div");
            if (uart_open)
                ud = DIV_W'(hz / ubaud);
        end
    endtask

    // ------------------------------------------------------------
    // Sleep entry, optional pin change, bounded wait for wake
    // ------------------------------------------------------------
    task automatic sleep(input logic [15:0] s, input logic ab, input int t);
        int n, lim;
        n   = 0;
        lim = (s == 0) ? 50 : (s + 1) * SC + 10;
        @(posedge clk);
        sleep_req <= 1'b1;
        secs      <= s;
        abort_en  <= ab;
        @(posedge clk);
        sleep_req <= 1'b0;
        @(negedge clk);
        @(negedge clk);
        chk(o_core_halt === 1'b1, "no halt");
        chk(o_wake_pin_input === (s == 0), "wake pin mode");
        repeat (t) @(posedge clk);
        wake_tgl  <= (s == 0);
        abort_tgl <= ab;
        @(posedge clk);
        wake_tgl  <= 1'b0;
        abort_tgl <= 1'b0;
        while (o_core_halt !== 1'b0 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        chk(n < lim, "wake too late");
        // Let the pulse counters see the last wake edge
        @(negedge clk);
    endtask

    always @(negedge clk)
    begin
        if (o_ir_decode_start === 1'b1)
            irs++;
        if (o_time_advance === 1'b1)
            tadv++;
        if (o_freq_ack === 1'b1 || o_freq_reject === 1'b1)
        begin
            if (expq.size() == 0)
                chk(1'b0, "stray answer");
            else
            begin
                me = expq.pop_front();
                chk(o_freq_ack === me.ack && o_freq_reject === !me.ack &&
                    o_freq_half_mhz === me.f, "freq answer");
            end
        end
    end

    initial
    begin
        #200000;
        bad_count++;
        end_of_test;
    end

    initial
    begin
        void'($urandom(32'hdfb4));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        wait_idle;
        chk(o_freq_half_mhz === F_SMALL_RESET && o_feature_en === FEAT_ALL,
            "reset state");
        chk(o_console_div === DIV_W'(F_SMALL_RESET * HALF_MHZ_HZ / cbaud) &&
            o_uart_div === DIV_W'(F_SMALL_RESET * HALF_MHZ_HZ / ubaud),
            "reset divisors");
        foreach (SMALL_LIST[i])
        begin
            @(posedge clk);
            cbaud <= 18'($urandom_range(32'h0001c200, 32'h00000960));
            set_freq(SMALL_LIST[i]);
            set_freq(8'($urandom_range(32'h000000ff, 32'h00000000)));
        end
        set_freq(8'hf0);
        @(posedge clk);
        uart_open <= 1'b0;
        set_freq(F_SMALL_RESET);
        sleep(16'h0000, 1'b0, 5);
        chk(irs == 1, "ir decode on wake");
        @(posedge clk);
        ir_act <= 1'b0;
        sleep(16'h0000, 1'b0, 2);
        chk(irs == 1, "ir decode with receiver off");
        sleep(16'h0003, 1'b0, 0);
        chk(tadv == 1 && o_slept_secs === 16'h0003 &&
            o_sleep_aborted === 1'b0, "timed sleep");
        sleep(16'h000a, 1'b1, 30);
        chk(o_sleep_aborted === 1'b1 && o_slept_secs < 16'h000a,
            "abort");
        chk(expq.size() == 0, "missing freq answer");
        end_of_test;
    end
endmodule
